// File: pnr_pkg.sv
// Package for the per-nibble configuration register port: layout and constants
// What this block does
// - 74 registers, 16 bits, read/write
// - Each nibble has its own independent bank
// - Controller writes reserved bits as given; software keeps them
// - Calibration writes win over fabric writes
// - Collision drops grant, holds previous fabric write
// - After calibration, grant returns, held write done
// - Writes while grant low are discarded
// - Select reads; grant high means fabric owns
// - Read data after one cycle, write two
// - Write needs select and enable, grant high
// - Register-set serial mode cleared by calibration
// - Serial mode stays cleared after calibration; software sets it again
// - Bit 11 reads delay calibration done
// - Bit 12 mirrors the phy ready port
// - Bit 15 reads calibration engine paused
// - Bit 14 disables quarter delay tracking
package pnr_pkg;
   localparam int NUM_REGS   = 74;
   localparam int DATA_W     = 16;
   localparam int ADDR_W     = 7;
   localparam int NUM_NIBBLE = 9;
   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_CLK_GATING = 7'h00;
   localparam logic [ADDR_W-1:0] OFS_PHASE      = 7'h01;
   localparam logic [ADDR_W-1:0] OFS_CAL        = 7'h02;
   // Writable masks; reserved and read-only bits excluded
   localparam logic [DATA_W-1:0] MASK_CLK_GATING = 16'h007f;
   localparam logic [DATA_W-1:0] MASK_PHASE      = 16'h02ff;
   localparam logic [DATA_W-1:0] MASK_CAL        = 16'h4007;
   // Field positions
   localparam int BIT_SERIAL_MODE = 3;
   localparam int BIT_DELAY_DONE  = 11;
   localparam int BIT_PHY_READY   = 12;
   localparam int BIT_QDLY_OFF    = 14;
   localparam int BIT_PAUSED      = 15;
   // Cycles from access to completion
   localparam int RD_LATENCY = 1;
   localparam int WR_LATENCY = 2;
endpackage

// File: pnr_link_if.sv
// Interface joining the fabric controller and the nibble register port
`timescale 1ns/1ns
interface pnr_link_if (
   input wire logic aclk
);
   import pnr_pkg::*;
   logic              nibble_select;
   logic              reg_write_enable;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic              reg_access_grant;

   modport dev (
      input  nibble_select,
      input  reg_write_enable,
      input  reg_addr,
      input  reg_wdata,
      output reg_rdata,
      output reg_access_grant
   );
   modport ctl (
      output nibble_select,
      output reg_write_enable,
      output reg_addr,
      output reg_wdata,
      input  reg_rdata,
      input  reg_access_grant
   );
endinterface

// File: pnr_nibble_regs.sv
// Device end: one nibble's register bank with calibration arbitration
`timescale 1ns/1ns
module pnr_nibble_regs #(
   parameter logic [pnr_pkg::DATA_W-1:0] ATTR_CLK_GATING = 16'h0000,
   parameter logic [pnr_pkg::DATA_W-1:0] ATTR_PHASE      = 16'h0000,
   parameter logic [pnr_pkg::DATA_W-1:0] ATTR_CAL        = 16'h0000,
   parameter logic                       ATTR_SERIAL     = 1'b0
) (
   input wire logic                       aclk,
   input wire logic                       aresetn,
   pnr_link_if.dev                        link,
   input wire logic                       cal_active,
   input wire logic                       cal_wr_en,
   input wire logic [pnr_pkg::ADDR_W-1:0] cal_addr,
   input wire logic [pnr_pkg::DATA_W-1:0] cal_wdata,
   input wire logic                       delay_cal_done,
   input wire logic                       phy_ready,
   input wire logic                       cal_paused,
   output logic                           serial_mode_out,
   output logic                           quarter_delay_track_off
);
   import pnr_pkg::*;

   logic [DATA_W-1:0] regs_q [NUM_REGS];
   logic              serial_by_reg_q;
   logic              held_valid_q;
   logic [ADDR_W-1:0] held_addr_q;
   logic [DATA_W-1:0] held_data_q;
   logic              prev_wr_q;
   logic [ADDR_W-1:0] prev_addr_q;
   logic [DATA_W-1:0] prev_data_q;
   logic              grant_q;
   logic              wr_stage_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [DATA_W-1:0] wr_data_q;
   logic [DATA_W-1:0] rdata_q;
   logic              fab_wr;
   logic              commit;
   logic [ADDR_W-1:0] commit_addr;
   logic [DATA_W-1:0] commit_data;

   // Writable bits per register; reserved and status bits never stored
   function automatic logic [DATA_W-1:0] wmask(input logic [ADDR_W-1:0] a);
      if (a == OFS_CLK_GATING) begin
         wmask = MASK_CLK_GATING;
      end else if (a == OFS_PHASE) begin
         wmask = MASK_PHASE;
      end else if (a == OFS_CAL) begin
         wmask = MASK_CAL;
      end else begin
         wmask = '1;
      end
   endfunction

   // Fabric write accepted only while grant is high
   assign fab_wr = link.nibble_select && link.reg_write_enable && grant_q;

   // Grant follows calibration ownership; calibration always wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         grant_q <= 1'b0;
      end else begin
         grant_q <= !cal_active && !cal_wr_en;
      end
   end

   // Last fabric write, kept for the collision hold
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_wr_q   <= 1'b0;
         prev_addr_q <= '0;
         prev_data_q <= '0;
      end else begin
         prev_wr_q   <= fab_wr;
         prev_addr_q <= link.reg_addr;
         prev_data_q <= link.reg_wdata;
      end
   end

   // Hold the write from the cycle before grant fell; replay once back
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         held_valid_q <= 1'b0;
         held_addr_q  <= '0;
         held_data_q  <= '0;
      end else if (grant_q && cal_wr_en && fab_wr) begin
         held_valid_q <= 1'b1;
         held_addr_q  <= link.reg_addr;
         held_data_q  <= link.reg_wdata;
      end else if (!grant_q && prev_wr_q && !held_valid_q && cal_wr_en) begin
         held_valid_q <= 1'b1;
         held_addr_q  <= prev_addr_q;
         held_data_q  <= prev_data_q;
      end else if (grant_q && held_valid_q) begin
         held_valid_q <= 1'b0;
      end
   end

   // Stage 1 of write pipeline; held write goes first after grant returns
   always_comb begin
      commit      = 1'b0;
      commit_addr = link.reg_addr;
      commit_data = link.reg_wdata;
      if (grant_q && held_valid_q) begin
         commit      = 1'b1;
         commit_addr = held_addr_q;
         commit_data = held_data_q;
      end else if (fab_wr && !cal_wr_en) begin
         commit = 1'b1;
      end
   end

   // Second pipeline stage gives the two-cycle write latency
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_stage_q <= 1'b0;
         wr_addr_q  <= '0;
         wr_data_q  <= '0;
      end else begin
         wr_stage_q <= commit;
         wr_addr_q  <= commit_addr;
         wr_data_q  <= commit_data;
      end
   end

   // Register storage; attribute values at reset, calibration writes first
   generate
      for (genvar i = 0; i < NUM_REGS; i++) begin : g_reg
         localparam logic [ADDR_W-1:0] IDX = ADDR_W'(i);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               if (i == OFS_CLK_GATING) begin
                  regs_q[i] <= ATTR_CLK_GATING & MASK_CLK_GATING;
               end else if (i == OFS_PHASE) begin
                  regs_q[i] <= ATTR_PHASE & MASK_PHASE;
               end else if (i == OFS_CAL) begin
                  regs_q[i] <= ATTR_CAL & MASK_CAL;
               end else begin
                  regs_q[i] <= '0;
               end
            end else if (cal_wr_en && cal_addr == IDX) begin
               regs_q[i] <= cal_wdata & wmask(IDX);
            end else if (i == OFS_CLK_GATING && cal_active && serial_by_reg_q) begin
               regs_q[i][BIT_SERIAL_MODE] <= 1'b0;
            end else if (wr_stage_q && wr_addr_q == IDX) begin
               regs_q[i] <= wr_data_q & wmask(IDX);
            end
         end
      end
   endgenerate

   // Tracks whether serial mode came from a write rather than the attribute
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_by_reg_q <= 1'b0;
      end else if (wr_stage_q && wr_addr_q == OFS_CLK_GATING) begin
         serial_by_reg_q <= wr_data_q[BIT_SERIAL_MODE] && !ATTR_SERIAL;
      end
   end

   // Read path, one cycle; status bits come live from the engine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_q <= '0;
      end else if (link.nibble_select && !link.reg_write_enable) begin
         if (link.reg_addr >= ADDR_W'(NUM_REGS)) begin
            rdata_q <= '0; // Unmapped reads as zero
         end else if (link.reg_addr == OFS_CAL) begin
            rdata_q <= regs_q[OFS_CAL];
            rdata_q[BIT_DELAY_DONE] <= delay_cal_done;
            rdata_q[BIT_PHY_READY]  <= phy_ready;
            rdata_q[BIT_PAUSED]     <= cal_paused;
         end else begin
            rdata_q <= regs_q[link.reg_addr];
         end
      end
   end

   // Outputs registered; one instance serves exactly one nibble
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         serial_mode_out         <= 1'b0;
         quarter_delay_track_off <= 1'b0;
      end else begin
         serial_mode_out         <= regs_q[OFS_CLK_GATING][BIT_SERIAL_MODE];
         quarter_delay_track_off <= regs_q[OFS_CAL][BIT_QDLY_OFF];
      end
   end

   assign link.reg_rdata        = rdata_q;
   assign link.reg_access_grant = grant_q;
endmodule

// File: pnr_fabric_ctrl.sv
// Fabric end: AXI4-Lite driven controller issuing register accesses
`timescale 1ns/1ns
module pnr_fabric_ctrl (
   input wire logic        aclk,
   input wire logic        aresetn,
   pnr_link_if.ctl         link,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   output logic            s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   output logic            s_axi_wready,
   output logic [1:0]      s_axi_bresp,
   output logic            s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   output logic            s_axi_arready,
   output logic [31:0]     s_axi_rdata,
   output logic [1:0]      s_axi_rresp,
   output logic            s_axi_rvalid,
   input wire logic        s_axi_rready,
   output logic            irq
);
   import pnr_pkg::*;

   localparam logic [7:0] A_CMD    = 8'h00; // [6:0] addr, [16] write, [17] go
   localparam logic [7:0] A_WDATA  = 8'h04;
   localparam logic [7:0] A_RDATA  = 8'h08;
   localparam logic [7:0] A_STATUS = 8'h0c; // [0] done [1] grant lost
   localparam logic [7:0] A_MASK   = 8'h10;

   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_WAIT2} pnr_st_t;
   pnr_st_t           st_q;
   logic              aw_q, w_q, go;
   logic [7:0]        awa_q;
   logic [31:0]       wd_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdat_q, rdat_q;
   logic              is_wr_q, sel_q, we_q;
   logic [1:0]        sts_q, msk_q, ev;

   // Write address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q  <= 1'b0;
         awa_q <= '0;
         wd_q  <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q  <= 1'b1;
            awa_q <= s_axi_awaddr[7:0];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q  <= 1'b1;
            wd_q <= s_axi_wdata;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
         end
      end
   end
   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;
   assign go = aw_q && w_q && !s_axi_bvalid && awa_q == A_CMD && wd_q[17] && st_q == ST_IDLE;

   // Response one cycle after both halves present
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end else if (aw_q && w_q && !s_axi_bvalid) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awa_q > A_MASK || awa_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
      end
   end

   // Software registers; mask, write data, command fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         msk_q  <= '0;
         wdat_q <= '0;
         addr_q <= '0;
         is_wr_q <= 1'b0;
      end else if (aw_q && w_q && !s_axi_bvalid && s_axi_wstrb != 4'h0) begin
         if (awa_q == A_MASK) begin
            msk_q <= wd_q[1:0];
         end else if (awa_q == A_WDATA) begin
            wdat_q <= wd_q[DATA_W-1:0]; // software keeps reserved bits
         end else if (awa_q == A_CMD && st_q == ST_IDLE) begin
            addr_q  <= wd_q[ADDR_W-1:0];
            is_wr_q <= wd_q[16];
         end
      end
   end

   // Link sequencer; one access per command, flags a write that saw grant low
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q  <= ST_IDLE;
         sel_q <= 1'b0;
         we_q  <= 1'b0;
         rdat_q <= '0;
         ev    <= '0;
      end else begin
         ev <= '0;
         case (st_q)
            ST_IDLE: begin
               if (go) begin
                  sel_q <= 1'b1;
                  we_q  <= wd_q[16];
                  st_q  <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!link.reg_access_grant) begin
                  ev[1] <= we_q; // Write is discarded by the device
               end
               sel_q <= 1'b0;
               we_q  <= 1'b0;
               st_q  <= ST_WAIT2;
            end
            default: begin
               if (!is_wr_q) begin
                  rdat_q <= link.reg_rdata;
               end
               ev[0] <= 1'b1;
               st_q  <= ST_IDLE; // software re-sets serial mode after cal
            end
         endcase
      end
   end

   // Sticky status, write one to clear, set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sts_q <= '0;
      end else if (aw_q && w_q && !s_axi_bvalid && awa_q == A_STATUS) begin
         sts_q <= (sts_q & ~wd_q[1:0]) | ev;
      end else begin
         sts_q <= sts_q | ev;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(sts_q & msk_q);
      end
   end

   // Read channel answers one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= 2'h0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'h0;
         if (s_axi_araddr[7:0] == A_CMD) begin
            s_axi_rdata <= {14'h0, is_wr_q, st_q != ST_IDLE, 9'h0, addr_q};
         end else if (s_axi_araddr[7:0] == A_WDATA) begin
            s_axi_rdata <= {16'h0, wdat_q};
         end else if (s_axi_araddr[7:0] == A_RDATA) begin
            s_axi_rdata <= {16'h0, rdat_q};
         end else if (s_axi_araddr[7:0] == A_STATUS) begin
            s_axi_rdata <= {30'h0, sts_q};
         end else if (s_axi_araddr[7:0] == A_MASK) begin
            s_axi_rdata <= {30'h0, msk_q};
         end else begin
            s_axi_rdata <= '0;
            s_axi_rresp <= 2'h2;
         end
      end
   end

   assign link.nibble_select    = sel_q;
   assign link.reg_write_enable = we_q;
   assign link.reg_addr         = addr_q;
   assign link.reg_wdata        = wdat_q;
endmodule

// File: pnr_link_monitor.sv
// Checker watching the link between the fabric controller and the register port
`timescale 1ns/1ns
module pnr_link_monitor (
   input wire logic                       aclk,
   input wire logic                       aresetn,
   input wire logic                       nibble_select,
   input wire logic                       reg_write_enable,
   input wire logic [pnr_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pnr_pkg::DATA_W-1:0] reg_wdata,
   input wire logic [pnr_pkg::DATA_W-1:0] reg_rdata,
   input wire logic                       reg_access_grant
);
   import pnr_pkg::*;
   logic [DATA_W-1:0] shadow_q;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Last granted fabric value of the clock gating register; attributes reset to zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shadow_q <= '0;
      end else if (nibble_select && reg_write_enable && reg_access_grant
                   && reg_addr == OFS_CLK_GATING) begin
         shadow_q <= reg_wdata & MASK_CLK_GATING;
      end
   end

   sequence rd_at(logic [ADDR_W-1:0] a);
      nibble_select && !reg_write_enable && reg_addr == a;
   endsequence
   sequence rd_unmapped;
      nibble_select && !reg_write_enable && reg_addr >= NUM_REGS;
   endsequence

   wren_with_sel_a: assert property (reg_write_enable |-> nibble_select)
      else $error("write enable without select");
   access_spacing_a: assert property (nibble_select |=> !nibble_select [*2])
      else $error("accesses closer than three cycles");
   rdata_cause_a: assert property ($changed(reg_rdata) |-> $past(nibble_select) && !$past(reg_write_enable))
      else $error("read data moved without a read one cycle before");
   ctrl0_reserved_a: assert property (rd_at(OFS_CLK_GATING) |=> (reg_rdata & 16'hff80) == '0)
      else $error("gating register reserved bits not zero");
   ctrl1_reserved_a: assert property (rd_at(OFS_PHASE) |=> (reg_rdata & 16'hfd00) == '0)
      else $error("phase register reserved bits not zero");
   cal_reserved_a: assert property (rd_at(OFS_CAL) |=> (reg_rdata & 16'h27f8) == '0)
      else $error("calibration register reserved bits not zero");
   unmapped_zero_a: assert property (rd_unmapped |=> reg_rdata == '0)
      else $error("unmapped register read not zero");
   // Serial bit left out: calibration may clear it behind the fabric's back
   ctrl0_shadow_a: assert property (rd_at(OFS_CLK_GATING) |=> ((reg_rdata ^ shadow_q) & 16'h0077) == '0)
      else $error("gating register read differs from last granted write");
endmodule

// File: phy_nibble_register_interface_tb_top.sv
// Testbench driving both ends of the nibble register link over AXI4-Lite
`timescale 1ns/1ns
module phy_nibble_register_interface_tb_top;
   import pnr_pkg::*;
   logic              aclk, aresetn, awvalid, wvalid, bvalid, bready, awready, wready;
   logic              arvalid, rvalid, rready, arready, irq, serial_out, qdly_off;
   logic              cal_active, cal_wr_en, dly_done, phy_rdy, paused;
   logic [31:0]       awaddr, wdata, araddr, rdata, v, st;
   logic [1:0]        bresp, rresp;
   logic [ADDR_W-1:0] cal_addr;
   logic [DATA_W-1:0] cal_wdata;
   logic [DATA_W-1:0] w [3];
   logic [65:0]       note;
   logic [65:0]       rd_q [$];
   logic [1:0]        wr_q [$];
   int                miscompares, n_tests, i, j, n;
   logic [15:0] cmp [3] = '{16'hffff, 16'hffff, 16'h67ff};
   logic [15:0] wm [3] = '{MASK_CLK_GATING, MASK_PHASE, MASK_CAL};

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   pnr_link_if i_pnr_link_if (.aclk(aclk));
   pnr_nibble_regs i_pnr_nibble_regs (.aclk(aclk), .aresetn(aresetn), .link(i_pnr_link_if),
      .cal_active(cal_active), .cal_wr_en(cal_wr_en), .cal_addr(cal_addr),
      .cal_wdata(cal_wdata), .delay_cal_done(dly_done), .phy_ready(phy_rdy),
      .cal_paused(paused), .serial_mode_out(serial_out), .quarter_delay_track_off(qdly_off));
   pnr_fabric_ctrl i_pnr_fabric_ctrl (.aclk(aclk), .aresetn(aresetn), .link(i_pnr_link_if),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq(irq));
   pnr_link_monitor i_pnr_link_monitor (.aclk(aclk), .aresetn(aresetn),
      .nibble_select(i_pnr_link_if.nibble_select),
      .reg_write_enable(i_pnr_link_if.reg_write_enable), .reg_addr(i_pnr_link_if.reg_addr),
      .reg_wdata(i_pnr_link_if.reg_wdata), .reg_rdata(i_pnr_link_if.reg_rdata),
      .reg_access_grant(i_pnr_link_if.reg_access_grant));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize;
      if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Each bus task opens on a fresh edge so no signal is driven twice in one step
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      @(posedge aclk);
      wr_q.push_back(er);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (k == 100) begin
         miscompares++;
         summarize();
      end
   endtask

   task automatic axi_rd(input logic [31:0] a, input logic [1:0] er, input logic [31:0] e,
                         input logic [31:0] m, output logic [31:0] d);
      int k;
      @(posedge aclk);
      rd_q.push_back({m, e & m, er});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      rready <= 1'b0;
      if (k == 100) begin
         miscompares++;
         summarize();
      end
   endtask

   // One link access through the command register, polled until it finishes
   task automatic link_go(input logic wr, input logic [6:0] a, input logic [15:0] d,
                          input logic clr);
      int k;
      axi_wr(32'h4, {16'h0, d}, 2'b00);
      axi_wr(32'h0, {14'h0, 1'b1, wr, 9'h0, a}, 2'b00);
      for (k = 0; k < 20; k++) begin
         axi_rd(32'hc, 2'b00, 32'h0, 32'h0, st);
         if (st[1:0] != 2'b00) break;
      end
      if (k == 20) begin
         miscompares++;
         summarize();
      end
      if (clr) axi_wr(32'hc, 32'h3, 2'b00);
   endtask

   task automatic link_rd(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
      logic [31:0] d;
      link_go(1'b0, a, 16'h0, 1'b1);
      axi_rd(32'h8, 2'b00, {16'h0, e}, {16'h0, m}, d);
   endtask

   // Result watcher: every bus answer is matched against the oldest note
   always @(posedge aclk) begin
      if (rvalid && rready && rd_q.size() > 0) begin
         note = rd_q.pop_front();
         check(rdata & note[65:34], note[33:2]);
         check({30'h0, rresp}, {30'h0, note[1:0]});
      end
      if (bvalid && bready && wr_q.size() > 0) check({30'h0, bresp}, {30'h0, wr_q.pop_front()});
   end

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {cal_active, cal_wr_en, dly_done, phy_rdy, paused} = '0;
      {awaddr, wdata, araddr} = '0;
      cal_addr = '0;
      cal_wdata = '0;
      miscompares = 0;
      n_tests = 0;
      void'($urandom(32'h6483));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      check(irq, 1'b0);
      link_rd(OFS_CLK_GATING, 16'h0, 16'hffff);
      // Status bits follow their inputs
      for (i = 0; i < 4; i++) begin
         v = $urandom();
         dly_done <= v[0];
         phy_rdy  <= v[1];
         paused   <= v[2];
         link_rd(OFS_CAL, {v[2], 2'b00, v[1], v[0], 11'h0}, 16'h9800);
      end
      // Random data; reserved bits written as zero, so read back as zero
      for (j = 0; j < 3; j++) begin
         for (i = 0; i < 3; i++) begin
            v = $urandom() & {16'h0, wm[i]};
            w[i] = v[15:0];
            link_go(1'b1, i[6:0], v[15:0], 1'b1);
            link_rd(i[6:0], v[15:0], cmp[i]);
         end
      end
      check(serial_out, w[0][3]);
      check(qdly_off, w[2][14]);
      link_rd(7'd74, 16'h0, 16'hffff);
      axi_wr(32'h40, 32'h0, 2'b10);
      axi_rd(32'h40, 2'b10, 32'h0, 32'h0, v);
      // Interrupt raised, cleared, then masked
      axi_wr(32'h10, 32'h1, 2'b00);
      link_go(1'b0, 7'd0, 16'h0, 1'b0);
      check(irq, 1'b1);
      axi_wr(32'hc, 32'h3, 2'b00);
      axi_rd(32'hc, 2'b00, 32'h0, 32'h3, v);
      check(irq, 1'b0);
      axi_wr(32'h10, 32'h0, 2'b00);
      link_go(1'b0, 7'd0, 16'h0, 1'b0);
      check(irq, 1'b0);
      axi_wr(32'hc, 32'h3, 2'b00);
      // Engine write in the very cycle of a fabric write: fabric one held, replayed last
      v = $urandom();
      cal_addr <= OFS_PHASE;
      cal_wdata <= ~v[15:0];
      fork
         link_go(1'b1, OFS_PHASE, v[15:0] & MASK_PHASE, 1'b1);
         for (n = 0; n < 400; n++) begin
            @(posedge aclk);
            if (i_pnr_fabric_ctrl.go) begin
               cal_wr_en <= 1'b1;
               @(posedge aclk);
               cal_wr_en <= 1'b0;
               break;
            end
         end
      join
      check(n < 400, 1'b1);
      link_rd(OFS_PHASE, v[15:0] & MASK_PHASE, 16'hffff);
      // Calibration: serial bit cleared, grant withdrawn, engine write wins
      link_go(1'b1, OFS_CLK_GATING, 16'h0008, 1'b1);
      cal_active <= 1'b1;
      for (n = 0; n < 10; n++) begin
         @(posedge aclk);
         if (!i_pnr_link_if.reg_access_grant && !serial_out) break;
      end
      check({i_pnr_link_if.reg_access_grant, serial_out}, 2'b00);
      v = $urandom();
      cal_wr_en <= 1'b1;
      cal_addr  <= OFS_PHASE;
      cal_wdata <= v[15:0];
      @(posedge aclk);
      cal_wr_en <= 1'b0;
      link_go(1'b1, OFS_PHASE, ~v[15:0], 1'b1);
      check(st[1], 1'b1);
      cal_active <= 1'b0;
      for (n = 0; n < 10; n++) begin
         @(posedge aclk);
         if (i_pnr_link_if.reg_access_grant) break;
      end
      check(i_pnr_link_if.reg_access_grant, 1'b1);
      link_rd(OFS_PHASE, v[15:0] & MASK_PHASE, 16'hffff);
      link_rd(OFS_CLK_GATING, 16'h0, 16'h0008);
      summarize();
   end
endmodule
